// ---- pkg/mbad_pkg.sv ----
package mbad_pkg;
  // Control-space locations of the two base registers (movec selector).
  localparam logic [11:0] CTL_SECOND_BASE = 12'h0C0E;
  localparam logic [11:0] CTL_FIRST_BASE  = 12'h0C0F;
  // Field positions in the first base register.
  localparam int BASE_MSB   = 31;
  localparam int BASE_LSB   = 12;
  localparam int BIT_WP     = 8;
  localparam int BIT_ALT_MASTER_MASK      = 6;
  localparam int BIT_IACK_MASK            = 5;
  localparam int BIT_SUPERVISOR_CODE_MASK = 4;
  localparam int BIT_SUPERVISOR_DATA_MASK = 3;
  localparam int BIT_USER_CODE_MASK       = 2;
  localparam int BIT_USER_DATA_MASK       = 1;
  localparam int BIT_VALID  = 0;
  // Second register decodes on the top two address bits.
  localparam int BASE2_LSB  = 30;
  // Region size of the first register: 4 KByte.
  localparam int FIRST_REGION_BYTES = 4096;
  // Routing targets of a decoded access.
  typedef enum logic [1:0]
  {
    MBAD_TGT_SRAM   = 2'b00,
    MBAD_TGT_FIRST  = 2'b01,
    MBAD_TGT_SECOND = 2'b10,
    MBAD_TGT_EXT    = 2'b11
  } mbad_target_t;
endpackage : mbad_pkg

// ---- logic/mbad_first_match.sv ----
`timescale 1ns/1ps
module mbad_first_match
(
  // Register contents.
  input  wire logic [31:0] base_ff,
  // Access attributes.
  input  wire logic [31:0] addr,
  input  wire logic        wr,
  input  wire logic        supervisor,
  input  wire logic        code,
  input  wire logic        alt_master,
  input  wire logic        iack,
  // Result.
  output logic             hit,
  output logic             wp_block
);
  logic mask_hit;
  logic addr_hit;

  // Attribute masks; an alternate master ignores the four kind masks (not the iack mask) when its mask bit is clear.
  always_comb
  begin
    mask_hit = 1'b0;
    if (!(alt_master && !base_ff[mbad_pkg::BIT_ALT_MASTER_MASK]))
    begin
      if (supervisor && code && base_ff[mbad_pkg::BIT_SUPERVISOR_CODE_MASK])
        mask_hit = 1'b1;
      if (supervisor && !code && base_ff[mbad_pkg::BIT_SUPERVISOR_DATA_MASK])
        mask_hit = 1'b1;
      if (!supervisor && code && base_ff[mbad_pkg::BIT_USER_CODE_MASK])
        mask_hit = 1'b1;
      if (!supervisor && !code && base_ff[mbad_pkg::BIT_USER_DATA_MASK])
        mask_hit = 1'b1;
    end
    if (alt_master && base_ff[mbad_pkg::BIT_ALT_MASTER_MASK])
      mask_hit = 1'b1;
    if (iack && base_ff[mbad_pkg::BIT_IACK_MASK])
      mask_hit = 1'b1;
  end

  // Upper twenty address bits select a 4 KByte region.
  assign addr_hit = addr[mbad_pkg::BASE_MSB:mbad_pkg::BASE_LSB]
                    == base_ff[mbad_pkg::BASE_MSB:mbad_pkg::BASE_LSB];
  assign hit      = base_ff[mbad_pkg::BIT_VALID] && addr_hit && !mask_hit;
  // A write into a protected region is flagged rather than silently dropped.
  assign wp_block = hit && wr && base_ff[mbad_pkg::BIT_WP];
endmodule : mbad_first_match

// ---- logic/mbad_second_match.sv ----
`timescale 1ns/1ps
module mbad_second_match
(
  // Register contents.
  input  wire logic [31:0] base2_ff,
  // Access address.
  input  wire logic [31:0] addr,
  // Result.
  output logic             hit
);
  // One region on 1024 MByte boundaries, so only two bits compare.
  assign hit = base2_ff[mbad_pkg::BIT_VALID]
               && (addr[31:mbad_pkg::BASE2_LSB] == base2_ff[31:mbad_pkg::BASE2_LSB]);
endmodule : mbad_second_match

// ---- logic/mbad_decode.sv ----
`timescale 1ns/1ps
module mbad_decode
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Control-register write port from the core.
  input  wire logic        ctl_wr,
  input  wire logic [11:0] ctl_sel,
  input  wire logic [31:0] ctl_wdata,
  input  wire logic        ctl_supervisor,
  // Debug read port.
  input  wire logic        dbg_mode,
  input  wire logic        dbg_rd,
  input  wire logic [11:0] dbg_sel,
  output logic [31:0]      dbg_rdata,
  output logic             dbg_rvalid,
  // Processor bus access.
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_addr,
  input  wire logic        acc_wr,
  input  wire logic        acc_supervisor,
  input  wire logic        acc_code,
  input  wire logic        acc_alt_master,
  input  wire logic        acc_iack,
  input  wire logic        sram_hit,
  // Routing outcome.
  output logic             route_sram,
  output logic             route_first,
  output logic             route_second,
  output logic             route_ext,
  output logic             route_wp_error,
  output logic [1:0]       route_target
);
  logic [31:0] base_ff;
  logic [31:0] base2_ff;
  logic        valid_ff;
  logic        valid2_ff;
  logic        first_hit;
  logic        second_hit;
  logic        wp_block;
  logic [31:0] base_view;
  logic [31:0] base2_view;
  logic        wr_first;
  logic        wr_second;

  // Only supervisor writes at the two control locations land.
  assign wr_first  = ctl_wr && ctl_supervisor
                     && (ctl_sel == mbad_pkg::CTL_FIRST_BASE);
  assign wr_second = ctl_wr && ctl_supervisor
                     && (ctl_sel == mbad_pkg::CTL_SECOND_BASE);

  // Of the two base registers, the valid flags are the only bits with a reset value.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_ff  <= 1'b0;
      valid2_ff <= 1'b0;
    end
    else
    begin
      if (wr_first)
        valid_ff <= ctl_wdata[mbad_pkg::BIT_VALID];
      if (wr_second)
        valid2_ff <= ctl_wdata[mbad_pkg::BIT_VALID];
    end
  end

  // Remaining bits keep no reset, so reset does not disturb them.
  // The price is that they read as unknown until software first writes them.
  always_ff @(posedge sys_clk)
  begin
    if (wr_first)
      base_ff <= ctl_wdata;
    if (wr_second)
      base2_ff <= ctl_wdata;
  end

  assign base_view  = {base_ff[31:1], valid_ff};
  assign base2_view = {base2_ff[31:1], valid2_ff};

  // Debug read; normal software has no read path at all.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dbg_rdata  <= 32'h0000_0000;
      dbg_rvalid <= 1'b0;
    end
    else
    begin
      dbg_rvalid <= dbg_rd && dbg_mode;
      if (dbg_rd && dbg_mode)
      begin
        if (dbg_sel == mbad_pkg::CTL_FIRST_BASE)
          dbg_rdata <= base_view;
        else if (dbg_sel == mbad_pkg::CTL_SECOND_BASE)
          dbg_rdata <= base2_view;
        else
          dbg_rdata <= 32'h0000_0000;
      end
    end
  end

  mbad_first_match u_first
  (
    .base_ff    (base_view),
    .addr       (acc_addr),
    .wr         (acc_wr),
    .supervisor (acc_supervisor),
    .code       (acc_code),
    .alt_master (acc_alt_master),
    .iack       (acc_iack),
    .hit        (first_hit),
    .wp_block   (wp_block)
  );

  mbad_second_match u_second
  (
    .base2_ff (base2_view),
    .addr     (acc_addr),
    .hit      (second_hit)
  );

  // Priority: SRAM, then first, then second, else external decode.
  // A protected write is flagged here instead of leaking out to the external decode.
  always_comb
  begin
    route_sram     = 1'b0;
    route_first    = 1'b0;
    route_second   = 1'b0;
    route_ext      = 1'b0;
    route_wp_error = 1'b0;
    route_target   = mbad_pkg::MBAD_TGT_EXT;
    if (acc_valid)
    begin
      if (sram_hit)
      begin
        route_sram   = 1'b1;
        route_target = mbad_pkg::MBAD_TGT_SRAM;
      end
      else if (first_hit)
      begin
        route_first    = !wp_block;
        route_wp_error = wp_block;
        route_target   = mbad_pkg::MBAD_TGT_FIRST;
      end
      else if (second_hit)
      begin
        route_second = 1'b1;
        route_target = mbad_pkg::MBAD_TGT_SECOND;
      end
      else
      begin
        route_ext = 1'b1;
      end
    end
  end

  // Checks.
  // Reset and register write path first, routing afterwards.
  a_reset_valid_clear : assert property (@(posedge sys_clk)
    $rose(rst_n) |-> !valid_ff && !valid2_ff)
    else $error("valid flag not cleared by reset");
  a_user_write_ignored : assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctl_wr && !ctl_supervisor |=> $stable(valid_ff) && $stable(valid2_ff))
    else $error("user write changed a base register");
  a_first_sel_write : assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_first |=> valid_ff == $past(ctl_wdata[0]))
    else $error("first register write lost");
  a_debug_read_gate : assert property (@(posedge sys_clk) disable iff (!rst_n)
    dbg_rvalid |-> $past(dbg_mode))
    else $error("register read outside debug mode");
  a_sram_priority : assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc_valid && sram_hit |-> route_sram && !route_first && !route_second)
    else $error("sram did not take priority");
  a_miss_external : assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc_valid && !sram_hit && !first_hit && !second_hit |-> route_ext)
    else $error("miss not routed externally");
  a_invalid_no_decode : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !valid_ff && !valid2_ff |-> !route_first && !route_second)
    else $error("invalid region decoded");
  a_second_region_hit : assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc_valid && !sram_hit && !first_hit && valid2_ff
    && acc_addr[31:30] == base2_ff[31:30] |-> route_second)
    else $error("second region missed");
  a_write_protect : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_first && acc_wr |-> !base_ff[mbad_pkg::BIT_WP])
    else $error("write into protected region");
  a_first_addr_match : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_first |-> acc_addr[31:12] == base_ff[31:12])
    else $error("first region hit without address match");
  a_supv_code_mask : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_first && !acc_alt_master && acc_supervisor && acc_code
    |-> !base_ff[mbad_pkg::BIT_SUPERVISOR_CODE_MASK])
    else $error("masked supervisor code access decoded");

  // Attribute masks: a masked access must never reach the first region.
  a_supv_data_mask : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_first && !acc_alt_master && acc_supervisor && !acc_code
    |-> !base_ff[mbad_pkg::BIT_SUPERVISOR_DATA_MASK])
    else $error("masked supervisor data access decoded");
  a_user_code_mask : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_first && !acc_alt_master && !acc_supervisor && acc_code
    |-> !base_ff[mbad_pkg::BIT_USER_CODE_MASK])
    else $error("masked user code access decoded");
  a_user_data_mask : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_first && !acc_alt_master && !acc_supervisor && !acc_code
    |-> !base_ff[mbad_pkg::BIT_USER_DATA_MASK])
    else $error("masked user data access decoded");
  // An alternate master or an iack cycle gets through only with its own mask clear.
  a_alt_master_mask : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_first && acc_alt_master |-> !base_ff[mbad_pkg::BIT_ALT_MASTER_MASK])
    else $error("masked alternate master access decoded");
  a_iack_mask : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_first && acc_iack |-> !base_ff[mbad_pkg::BIT_IACK_MASK])
    else $error("masked iack cycle decoded");

  // Every access leaves by exactly one way, and an idle bus routes nowhere.
  a_route_onehot : assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc_valid
    |-> $onehot({route_sram, route_first, route_second, route_ext, route_wp_error}))
    else $error("access routed to no target or to several");
  a_idle_no_route : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !acc_valid |-> !route_sram && !route_first && !route_second && !route_ext
    && !route_wp_error)
    else $error("routing raised without an access");
  // The first region outranks the second; a protected write becomes an error, a read passes.
  a_first_over_second : assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc_valid && !sram_hit && first_hit
    |-> !route_second && (route_first || route_wp_error))
    else $error("second region won over first");
  a_wp_error_cause : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_wp_error |-> acc_wr && base_ff[mbad_pkg::BIT_WP] && !sram_hit)
    else $error("protection error without a protected write");
  a_wp_read_allowed : assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc_valid && !sram_hit && first_hit && !acc_wr |-> route_first)
    else $error("read of first region refused");
  a_first_needs_valid : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_first || route_wp_error |-> valid_ff)
    else $error("first region decoded while not valid");
  a_second_needs_match : assert property (@(posedge sys_clk) disable iff (!rst_n)
    route_second |-> valid2_ff && acc_addr[31:30] == base2_ff[31:30])
    else $error("second region decoded without a match");

  // Debug read in two steps: a request taken in debug mode, then the answer.
  sequence s_dbg_request;
    dbg_rd && dbg_mode;
  endsequence

  sequence s_dbg_answer;
    dbg_rvalid;
  endsequence

  // Requests aimed at one register each, for checking the data that comes back.
  sequence s_dbg_first_request;
    dbg_rd && dbg_mode && (dbg_sel == mbad_pkg::CTL_FIRST_BASE);
  endsequence

  sequence s_dbg_second_request;
    dbg_rd && dbg_mode && (dbg_sel == mbad_pkg::CTL_SECOND_BASE);
  endsequence

  a_debug_read_answer : assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_dbg_request |=> s_dbg_answer)
    else $error("debug read not answered");
  a_debug_mode_only : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(dbg_rd && dbg_mode) |=> !dbg_rvalid)
    else $error("register contents shown outside a debug read");
  a_debug_first_data : assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_dbg_first_request |=> dbg_rdata == $past(base_view))
    else $error("debug read of first register wrong");
  a_debug_second_data : assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_dbg_second_request |=> dbg_rdata == $past(base2_view))
    else $error("debug read of second register wrong");

  // A landed write keeps the whole word, valid bit included.
  a_second_sel_write : assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_second |=> valid2_ff == $past(ctl_wdata[mbad_pkg::BIT_VALID]))
    else $error("second register write lost");
  a_first_word_write : assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_first |=> base_view == $past(ctl_wdata))
    else $error("first register word not stored");
  a_second_word_write : assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_second |=> base2_view == $past(ctl_wdata))
    else $error("second register word not stored");
endmodule : mbad_decode

// ---- verif/mbad_sram_model.sv ----
`timescale 1ns/1ps
// Stands in for the SRAM base match that sits ahead of the peripheral decode.
module mbad_sram_model
(
  // Setup.
  input  wire logic        en,
  input  wire logic [15:0] base,
  // Access.
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_addr,
  // Match result.
  output logic             sram_hit
);
  // A 64 KByte granule is enough here; the real match is never finer.
  assign sram_hit = en & acc_valid & (acc_addr[31:16] == base);
endmodule : mbad_sram_model

// ---- verif/module_base_address_decode_test.sv ----
`timescale 1ns/1ps
module module_base_address_decode_test;
  logic        sys_clk, rst_n, ctl_wr, ctl_supervisor, dbg_mode, dbg_rd, dbg_rvalid;
  logic        acc_valid, acc_wr, acc_supervisor, acc_code, sram_hit, sram_en, acc_alt, acc_iack;
  logic        route_sram, route_first, route_second, route_ext, route_wp_error;
  logic [1:0]  route_target;
  logic [11:0] ctl_sel, dbg_sel;
  logic [15:0] sram_base;
  logic [31:0] ctl_wdata, dbg_rdata, acc_addr, fb, sb, r, q;
  int          num_errors, n_checks;

  mbad_decode uut (.sys_clk(sys_clk), .rst_n(rst_n), .ctl_wr(ctl_wr), .ctl_sel(ctl_sel),
    .ctl_wdata(ctl_wdata), .ctl_supervisor(ctl_supervisor), .dbg_mode(dbg_mode),
    .dbg_rd(dbg_rd), .dbg_sel(dbg_sel), .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_wr(acc_wr),
    .acc_supervisor(acc_supervisor), .acc_code(acc_code), .acc_alt_master(acc_alt),
    .acc_iack(acc_iack), .sram_hit(sram_hit), .route_sram(route_sram),
    .route_first(route_first), .route_second(route_second), .route_ext(route_ext),
    .route_wp_error(route_wp_error), .route_target(route_target));
  mbad_sram_model sram (.en(sram_en), .base(sram_base), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .sram_hit(sram_hit));

  // Free-running system clock, 8 ns period.
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Expected routing {sram, first, second, ext, wp} from the mirrored registers.
  function automatic logic [4:0] expv(logic [31:0] a, logic w, s, c, sr);
    int   m;
    logic blk;
    m = s ? (c ? 4 : 3) : (c ? 2 : 1);
    // An alternate master answers to its own mask bit only; iack cycles to theirs as well.
    blk = (acc_alt ? fb[6] : fb[m]) || (acc_iack && fb[5]);
    if (sr) return 5'b1_0000;
    if (fb[0] === 1'b1 && a[31:12] == fb[31:12] && blk === 1'b0)
      return (w && fb[8]) ? 5'b0_0001 : 5'b0_1000;
    if (sb[0] === 1'b1 && a[31:30] == sb[31:30]) return 5'b0_0100;
    return 5'b0_0010;
  endfunction : expv

  // Control-register write; the mirror follows only what the block should accept.
  task automatic wr_reg(logic [11:0] sel, logic [31:0] d, logic s);
    @(negedge sys_clk);
    {ctl_wr, ctl_sel, ctl_wdata, ctl_supervisor} = {1'b1, sel, d, s};
    @(negedge sys_clk);
    ctl_wr = 1'b0;
    if (s && sel == mbad_pkg::CTL_FIRST_BASE) fb = d;
    if (s && sel == mbad_pkg::CTL_SECOND_BASE) sb = d;
  endtask : wr_reg

  // Present one access and compare every routing output in the same cycle.
  task automatic acc(logic [31:0] a, logic w, s, c, logic alt = 1'b0, logic ia = 1'b0);
    logic [4:0] e;
    logic [1:0] t;
    @(negedge sys_clk);
    {acc_valid, acc_addr, acc_wr, acc_supervisor, acc_code} = {1'b1, a, w, s, c};
    {acc_alt, acc_iack} = {alt, ia};
    #1;
    e = expv(a, w, s, c, sram_en && a[31:16] == sram_base);
    // A refused protected write still names the first region as its target.
    t = e[4] ? 2'h0 : (e[3] || e[0]) ? 2'h1 : e[2] ? 2'h2 : 2'h3;
    n_checks++;
    if ({route_sram, route_first, route_second, route_ext, route_wp_error} !== e
        || route_target !== t)
    begin
      $display("ERROR %0t route mismatch addr %h", $time, a);
      num_errors++;
    end
  endtask : acc

  // Debug read: answer comes one cycle after the request, only in debug mode.
  task automatic dbg(logic [11:0] sel, logic m, logic [31:0] e);
    @(negedge sys_clk);
    {dbg_mode, dbg_rd, dbg_sel} = {m, 1'b1, sel};
    @(negedge sys_clk);
    dbg_rd = 1'b0;
    n_checks++;
    if (dbg_rvalid !== m || (m && dbg_rdata !== e))
    begin
      $display("ERROR %0t debug read sel %h", $time, sel);
      num_errors++;
    end
  endtask : dbg

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // Hang guard.
  initial
  begin
    #400_000;
    num_errors++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    {rst_n, ctl_wr, ctl_supervisor, dbg_mode, dbg_rd, acc_valid, acc_wr} = 7'h00;
    {acc_supervisor, acc_code, sram_en, ctl_sel, dbg_sel, ctl_wdata, acc_addr} = '0;
    {acc_alt, acc_iack} = 2'h0;
    sram_base = 16'h1000;
    fb = 'x;
    sb = 'x;
    fb[0] = 1'b0;
    sb[0] = 1'b0;
    void'($urandom(32'h58c2_2797));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    acc(32'h1000_0000, 1'b0, 1'b1, 1'b0);
    acc(32'h8000_0000, 1'b0, 1'b1, 1'b0);
    wr_reg(mbad_pkg::CTL_FIRST_BASE, 32'h1000_0001, 1'b0);
    acc(32'h1000_0000, 1'b0, 1'b1, 1'b0);
    wr_reg(mbad_pkg::CTL_FIRST_BASE, 32'h1000_0001, 1'b1);
    acc(32'h1000_0FFC, 1'b0, 1'b1, 1'b0);
    acc(32'h1000_1000, 1'b0, 1'b1, 1'b0);
    acc(32'h0FFF_FFFC, 1'b1, 1'b0, 1'b0);
    wr_reg(mbad_pkg::CTL_SECOND_BASE, 32'h8000_0001, 1'b1);
    acc(32'hBFFF_FFFC, 1'b0, 1'b1, 1'b1);
    acc(32'h7FFF_FFFC, 1'b0, 1'b1, 1'b1);
    dbg(mbad_pkg::CTL_FIRST_BASE, 1'b1, 32'h1000_0001);
    dbg(mbad_pkg::CTL_SECOND_BASE, 1'b1, 32'h8000_0001);
    dbg(mbad_pkg::CTL_FIRST_BASE, 1'b0, 32'h0000_0000);
    dbg(12'h0C0D, 1'b1, 32'h0000_0000);
    sram_en = 1'b1;
    acc(32'h1000_0004, 1'b0, 1'b1, 1'b0);
    acc(32'h2000_0000, 1'b0, 1'b1, 1'b0);
    sram_en = 1'b0;
    wr_reg(mbad_pkg::CTL_FIRST_BASE, 32'h1000_0101, 1'b1);
    acc(32'h1000_0020, 1'b1, 1'b1, 1'b0);
    acc(32'h1000_0020, 1'b0, 1'b1, 1'b0);
    // Each kind mask bit (1 to 4) against all four supervisor/user and code/data kinds.
    for (int b = 1; b <= 4; b++)
    begin
      wr_reg(mbad_pkg::CTL_FIRST_BASE, 32'h1000_0001 | (32'h1 << b), 1'b1);
      for (int k = 0; k < 4; k++) acc(32'h1000_0010, 1'b0, k[1], k[0]);
    end
    // Alternate master and iack cycles against their own mask bits.
    wr_reg(mbad_pkg::CTL_FIRST_BASE, 32'h1000_0009, 1'b1);
    acc(32'h1000_0010, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    acc(32'h1000_0010, 1'b0, 1'b1, 1'b0);
    wr_reg(mbad_pkg::CTL_FIRST_BASE, 32'h1000_0061, 1'b1);
    acc(32'h1000_0010, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    acc(32'h1000_0010, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    acc(32'h1000_0010, 1'b0, 1'b0, 1'b1);
    // Random traffic aimed at each region, with random masks and write protect.
    wr_reg(mbad_pkg::CTL_FIRST_BASE, 32'h1000_0001 | ($urandom & 32'h0000_017E), 1'b1);
    for (int i = 0; i < 300; i++)
    begin
      r = $urandom;
      sram_en = r[0];
      case (r[2:1])
        2'd0: r = {fb[31:12], r[11:0]};
        2'd1: r = {sb[31:30], r[29:0]};
        2'd2: r = {sram_base, r[15:0]};
        default: ;
      endcase
      q = $urandom;
      acc(r, q[0], q[1], q[2], q[3], q[4]);
    end
    // A second reset in mid-run drops both valid flags again.
    @(negedge sys_clk);
    {rst_n, sram_en} = 2'b00;
    @(negedge sys_clk);
    rst_n = 1'b1;
    fb[0] = 1'b0;
    sb[0] = 1'b0;
    acc(32'h1000_0000, 1'b0, 1'b1, 1'b0);
    acc(32'h8000_0000, 1'b0, 1'b1, 1'b0);
    // The stored bases outlive the reset; only their valid bits drop.
    dbg(mbad_pkg::CTL_FIRST_BASE, 1'b1, fb);
    dbg(mbad_pkg::CTL_SECOND_BASE, 1'b1, sb);
    // With no access presented nothing routes, and the target rests on external.
    @(negedge sys_clk);
    acc_valid = 1'b0;
    #1;
    n_checks++;
    if ({route_sram, route_first, route_second, route_ext, route_wp_error, route_target}
        !== 7'h03)
    begin
      $display("ERROR %0t routing raised while idle", $time);
      num_errors++;
    end
    complete_run();
  end
endmodule : module_base_address_decode_test
